/* File: cpic_params.svh */
// register map, field positions and reset values of the can pin and interrupt glue
`ifndef CPIC_PARAMS_SVH
`define CPIC_PARAMS_SVH
`define CPIC_OFF_PINCTL   12'h000
`define CPIC_OFF_FLAGS    12'h004
`define CPIC_OFF_ENABLES  12'h008
`define CPIC_RST_PINCTL   8'h00
`define CPIC_RST_FLAGS    8'h00
`define CPIC_RST_ENABLES  8'h00
`define CPIC_PINCTL_IMPL  8'hf1
`define CPIC_MASK_MODE0   8'hff
`define CPIC_MASK_MODE1   8'hf2
`define CPIC_MASK_MODE2   8'hf3
`define CPIC_MASK_TX_SUM  8'h10
`define CPIC_MASK_RX_SUM  8'h02
`define CPIC_BIT_INVALID  7
`define CPIC_BIT_WAKE     6
`define CPIC_BIT_ERR      5
`define CPIC_BIT_TX2      4
`define CPIC_BIT_TX1      3
`define CPIC_BIT_TX0      2
`define CPIC_BIT_RX1      1
`define CPIC_BIT_RX0      0
`endif

/* File: cpic_pkg.sv */
// types shared by the can pin and interrupt glue
`default_nettype none
package cpic_pkg;
  typedef enum logic [1:0] {
    CPIC_MODE_LEGACY = 2'h0,
    CPIC_MODE_ENH    = 2'h1,
    CPIC_MODE_FIFO   = 2'h3,
    CPIC_MODE_RSVD   = 2'h2
  } cpic_mode_t;

  typedef struct packed {
    logic       second_tx_pin_source_sel;
    logic       second_tx_pin_enable;
    logic       recessive_drive_high;
    logic       receive_capture_route;
    logic [2:0] reserved;
    logic       can_clock_source_sel;
  } cpic_pinctl_t;

  typedef struct packed {
    logic       invalid_msg;
    logic       bus_activity;
    logic [2:0] tx_done;
    logic [1:0] rx_full;
    logic       fifo_watermark;
  } cpic_evt_t;

  typedef struct packed {
    logic o;
    logic oe;
  } cpic_pin_t;

  typedef struct packed {
    cpic_pinctl_t pinctl;
    logic [7:0]   flags;
    logic [7:0]   enables;
    logic         port_sync1;
    logic         port_sync2;
    cpic_pin_t    primary_tx;
    logic         capture_in;
    logic [31:0]  rdata;
    logic         irq;
  } cpic_state_t;
endpackage
`default_nettype wire

/* File: cpic_top.sv */
// can pin routing, clock select and interrupt flag/enable registers on apb
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "cpic_params.svh"

module cpic_top
  import cpic_pkg::*;
#(
  parameter int NUM_ERR_SRC = 4
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire cpic_mode_t       can_mode,
  input  wire cpic_evt_t        can_evt,
  input  wire logic [NUM_ERR_SRC-1:0] module_err_src,
  input  wire logic [2:0]       per_tx_buffer_enable_reg,
  input  wire logic [7:0]       per_buffer_enable_reg,
  input  wire logic             core_tx_bit,
  input  wire logic             can_rx_msg,
  input  wire logic             capture_port_pin,
  input  wire logic             gpio_out,
  input  wire logic             gpio_oe,
  input  wire logic             osc_clk,
  input  wire logic             pll_clk,
  output logic                  primary_transmit_pin_o,
  output logic                  primary_transmit_pin_oe,
  output logic                  second_transmit_pin_o,
  output logic                  second_transmit_pin_oe,
  output logic                  first_capture_unit_in,
  output logic                  can_sys_clk,
  output logic                  can_irq
);

  generate
    if (NUM_ERR_SRC < 1)
    begin : g_chk
      $error("cpic_top: NUM_ERR_SRC must be at least one");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // bits that exist in a given mode; used for flags and enables alike
  function automatic logic [7:0] mode_mask(input cpic_mode_t m);
    logic [7:0] r;
    r = `CPIC_MASK_MODE2;
    unique case (m)
      CPIC_MODE_LEGACY: r = `CPIC_MASK_MODE0;
      CPIC_MODE_ENH:    r = `CPIC_MASK_MODE1;
      CPIC_MODE_FIFO:   r = `CPIC_MASK_MODE2;
      // reserved code behaves as the fifo mode
      default:          r = `CPIC_MASK_MODE2;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] flag_sets(input cpic_mode_t m,
                                           input cpic_evt_t  e,
                                           input logic       err);
    logic [7:0] s;
    s = 8'h00;
    s[`CPIC_BIT_INVALID] = e.invalid_msg;
    s[`CPIC_BIT_WAKE] = e.bus_activity;
    s[`CPIC_BIT_ERR] = err;
    if (m == CPIC_MODE_LEGACY)
    begin
      s[`CPIC_BIT_TX2] = e.tx_done[2];
      s[`CPIC_BIT_TX1] = e.tx_done[1];
      s[`CPIC_BIT_TX0] = e.tx_done[0];
      s[`CPIC_BIT_RX1] = e.rx_full[1];
      s[`CPIC_BIT_RX0] = e.rx_full[0];
    end
    else
    begin
      s[`CPIC_BIT_TX2] = |e.tx_done;
      s[`CPIC_BIT_RX1] = |e.rx_full;
      // watermark, masked off later in mode one
      s[`CPIC_BIT_RX0] = e.fifo_watermark;
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  cpic_state_t st_q;
  cpic_state_t st_d;

  logic        wr_acc;
  logic        rd_setup;
  logic        hit;
  logic [7:0]  mask;
  logic [7:0]  sets;
  logic [7:0]  pend;
  logic        tx_term;
  logic        rx_term;

  assign mask = mode_mask(can_mode);
  assign sets = flag_sets(can_mode, can_evt, |module_err_src);
  assign hit  = (paddr == `CPIC_OFF_PINCTL) || (paddr == `CPIC_OFF_FLAGS) ||
                (paddr == `CPIC_OFF_ENABLES);
  assign wr_acc   = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign pend     = st_q.flags & st_q.enables;

  // per-buffer enables only count behind the summary enable
  // summary tx enable gates them all
  assign tx_term = pend[`CPIC_BIT_TX2] && (|per_tx_buffer_enable_reg);
  // summary rx enable gates them all
  assign rx_term = pend[`CPIC_BIT_RX1] && (|per_buffer_enable_reg);

  always_comb
  begin
    st_d = st_q;
    // pin port comes from outside the clock domain
    st_d.port_sync1 = capture_port_pin;
    st_d.port_sync2 = st_q.port_sync1;

    if (wr_acc && paddr == `CPIC_OFF_PINCTL)
    begin
      st_d.pinctl = cpic_pinctl_t'(pwdata[7:0] & `CPIC_PINCTL_IMPL);
    end
    if (wr_acc && paddr == `CPIC_OFF_ENABLES)
    begin
      st_d.enables = pwdata[7:0];
    end
    if (wr_acc && paddr == `CPIC_OFF_FLAGS)
    begin
      st_d.flags = pwdata[7:0];
    end
    // sticky flags, a set beats a clear in the same cycle
    st_d.flags = st_d.flags | sets;
    // bit zero absent in mode one
    st_d.flags   = st_d.flags & mask;
    st_d.enables = st_d.enables & mask;

    // read data captured in setup so it is from a flop in the access phase
    if (rd_setup)
    begin
      st_d.rdata = 32'h0000_0000;
      if (paddr == `CPIC_OFF_PINCTL)
      begin
        // bits three to one read zero
        st_d.rdata[7:0] = st_q.pinctl & `CPIC_PINCTL_IMPL;
      end
      else if (paddr == `CPIC_OFF_FLAGS)
      begin
        st_d.rdata[7:0] = st_q.flags & mask;
      end
      else if (paddr == `CPIC_OFF_ENABLES)
      begin
        st_d.rdata[7:0] = st_q.enables & mask;
      end
    end

    // drive high when recessive, or release the line
    st_d.primary_tx.o  = core_tx_bit;
    st_d.primary_tx.oe = st_q.pinctl.recessive_drive_high || !core_tx_bit;

    st_d.capture_in = st_q.pinctl.receive_capture_route ? can_rx_msg : st_q.port_sync2;

    // each enable gates its own flag
    if (can_mode == CPIC_MODE_LEGACY)
    begin
      st_d.irq = |pend;
    end
    else
    begin
      // watermark enable, already zero in mode one
      st_d.irq = pend[`CPIC_BIT_INVALID] || pend[`CPIC_BIT_WAKE] ||
                 pend[`CPIC_BIT_ERR] || tx_term || rx_term ||
                 pend[`CPIC_BIT_RX0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q                    <= '0;
      st_q.pinctl             <= cpic_pinctl_t'(`CPIC_RST_PINCTL);
      st_q.flags              <= `CPIC_RST_FLAGS;
      st_q.enables            <= `CPIC_RST_ENABLES;
      st_q.primary_tx         <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = st_q.rdata;
  assign can_irq = st_q.irq;

  assign primary_transmit_pin_o  = st_q.primary_tx.o;
  assign primary_transmit_pin_oe = st_q.primary_tx.oe;
  assign first_capture_unit_in   = st_q.capture_in;

  // clock source; plain mux, so change it only while the can core is idle
  assign can_sys_clk = st_q.pinctl.can_clock_source_sel ? osc_clk : pll_clk;

  // second pin falls back to gpio when disabled
  // clock or the same tx data as the primary pin
  always_comb
  begin
    if (st_q.pinctl.second_tx_pin_enable)
    begin
      second_transmit_pin_o  = st_q.pinctl.second_tx_pin_source_sel ?
                               can_sys_clk : st_q.primary_tx.o;
      second_transmit_pin_oe = 1'b1;
    end
    else
    begin
      second_transmit_pin_o  = gpio_out;
      second_transmit_pin_oe = gpio_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  tx_released_a : assert property (
    core_tx_bit && !st_q.pinctl.recessive_drive_high |=> !primary_transmit_pin_oe)
    else $error("recessive bit not released");

  tx_drive_hi_a : assert property (
    core_tx_bit && st_q.pinctl.recessive_drive_high
      |=> primary_transmit_pin_oe && primary_transmit_pin_o)
    else $error("recessive bit not driven high");

  tx_dominant_a : assert property (
    !core_tx_bit |=> primary_transmit_pin_oe && !primary_transmit_pin_o)
    else $error("dominant bit not driven low");

  tx2_data_a : assert property (
    st_q.pinctl.second_tx_pin_enable && !st_q.pinctl.second_tx_pin_source_sel
      |-> second_transmit_pin_o == primary_transmit_pin_o && second_transmit_pin_oe)
    else $error("second pin does not follow tx data");

  tx2_gpio_a : assert property (
    !st_q.pinctl.second_tx_pin_enable
      |-> second_transmit_pin_o == gpio_out && second_transmit_pin_oe == gpio_oe)
    else $error("second pin not given back to gpio");

  cap_route_a : assert property (
    st_q.pinctl.receive_capture_route |=> first_capture_unit_in == $past(can_rx_msg))
    else $error("capture unit not fed by can receive");

  cap_pin_a : assert property (
    (!st_q.pinctl.receive_capture_route && capture_port_pin)[*3] |=> first_capture_unit_in)
    else $error("capture unit not fed by port pin");

  clk_sel_a : assert property (
    st_q.pinctl.can_clock_source_sel |-> can_sys_clk == osc_clk)
    else $error("can clock not from oscillator");

  rsvd_zero_a : assert property (
    psel && penable && !pwrite && paddr == `CPIC_OFF_PINCTL
      |-> prdata[3:1] == 3'h0 && prdata[31:8] == 24'h00_0000)
    else $error("unimplemented pin control bits not zero");

  invalid_set_a : assert property (
    can_evt.invalid_msg |=> st_q.flags[`CPIC_BIT_INVALID])
    else $error("invalid message flag not set");

  err_set_a : assert property (
    |module_err_src |=> st_q.flags[`CPIC_BIT_ERR])
    else $error("module error flag not set");

  tx_force_a : assert property (
    can_mode != CPIC_MODE_LEGACY
      |=> st_q.flags[`CPIC_BIT_TX1:`CPIC_BIT_TX0] == 2'h0 &&
          st_q.enables[`CPIC_BIT_TX1:`CPIC_BIT_TX0] == 2'h0)
    else $error("tx buffer one/zero bits not forced to zero");

  flag_hold_a : assert property (
    st_q.flags[`CPIC_BIT_INVALID] && !(wr_acc && paddr == `CPIC_OFF_FLAGS)
      |=> st_q.flags[`CPIC_BIT_INVALID])
    else $error("sticky flag lost without a write");

  irq_legacy_a : assert property (
    can_mode == CPIC_MODE_LEGACY && |(st_q.flags & st_q.enables) |=> can_irq)
    else $error("enabled flag raised no interrupt");

  tx_summary_a : assert property (
    can_mode != CPIC_MODE_LEGACY && !(|per_tx_buffer_enable_reg) &&
    !(|per_buffer_enable_reg) &&
    (st_q.flags & st_q.enables & ~(`CPIC_MASK_TX_SUM | `CPIC_MASK_RX_SUM)) == 8'h00
      |=> !can_irq)
    else $error("buffer interrupt without per-buffer enable");

  tx2_clock_a : assert property (
    st_q.pinctl.second_tx_pin_enable && st_q.pinctl.second_tx_pin_source_sel
      |-> second_transmit_pin_o == can_sys_clk && second_transmit_pin_oe)
    else $error("second pin does not carry the can clock");

  wake_set_a : assert property (
    can_evt.bus_activity |=> st_q.flags[`CPIC_BIT_WAKE])
    else $error("bus activity flag not set");

  legacy_tx_a : assert property (
    can_mode == CPIC_MODE_LEGACY && can_evt.tx_done[1] |=> st_q.flags[`CPIC_BIT_TX1])
    else $error("tx buffer one flag not set");

  tx_sum_set_a : assert property (
    can_mode != CPIC_MODE_LEGACY && |can_evt.tx_done |=> st_q.flags[`CPIC_BIT_TX2])
    else $error("tx summary flag not set");

  legacy_rx_a : assert property (
    can_mode == CPIC_MODE_LEGACY && can_evt.rx_full[0] |=> st_q.flags[`CPIC_BIT_RX0])
    else $error("rx buffer zero flag not set");

  rx_sum_set_a : assert property (
    can_mode != CPIC_MODE_LEGACY && |can_evt.rx_full |=> st_q.flags[`CPIC_BIT_RX1])
    else $error("rx summary flag not set");

  mode1_bit0_a : assert property (
    can_mode == CPIC_MODE_ENH
      |=> !st_q.flags[`CPIC_BIT_RX0] && !st_q.enables[`CPIC_BIT_RX0])
    else $error("bit zero not zero in mode one");

  wm_set_a : assert property (
    can_mode == CPIC_MODE_FIFO && can_evt.fifo_watermark |=> st_q.flags[`CPIC_BIT_RX0])
    else $error("watermark flag not set");

  wm_irq_a : assert property (
    can_mode == CPIC_MODE_FIFO && st_q.flags[`CPIC_BIT_RX0] && st_q.enables[`CPIC_BIT_RX0]
      |=> can_irq)
    else $error("watermark interrupt not raised");

  tx_sum_irq_a : assert property (
    can_mode != CPIC_MODE_LEGACY && st_q.flags[`CPIC_BIT_TX2] &&
    st_q.enables[`CPIC_BIT_TX2] && |per_tx_buffer_enable_reg |=> can_irq)
    else $error("enabled tx summary raised no interrupt");

  rx_sum_irq_a : assert property (
    can_mode != CPIC_MODE_LEGACY && st_q.flags[`CPIC_BIT_RX1] &&
    st_q.enables[`CPIC_BIT_RX1] && |per_buffer_enable_reg |=> can_irq)
    else $error("enabled rx summary raised no interrupt");

  // nothing pending must leave the request low in every mode
  irq_quiet_a : assert property (
    (st_q.flags & st_q.enables) == 8'h00 |=> !can_irq)
    else $error("interrupt without an enabled flag");

endmodule

`default_nettype wire

/* File: cpic_top_tb.sv */
// self-checking bench for the can pin and interrupt glue
`timescale 1ns/100ps
`default_nettype none
`include "cpic_params.svh"
module cpic_top_tb
  import cpic_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  cpic_mode_t  can_mode = CPIC_MODE_LEGACY;
  cpic_evt_t   can_evt = '0;
  logic [3:0]  err_src = '0;
  logic [2:0]  ptx = '0;
  logic [7:0]  pbuf = '0;
  logic        core_tx = 1'b1;
  logic        rx_msg = 1'b0;
  logic        port_pin = 1'b0;
  logic        gpio_o = 1'b1;
  logic        gpio_e = 1'b1;
  logic        osc = 1'b1;
  logic        pll = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        p_o;
  logic        p_oe;
  logic        s_o;
  logic        s_oe;
  logic        cap;
  logic        sclk;
  logic        irq;
  logic        bus_level;
  logic [31:0] rd;
  logic        se;
  int          num_errors = 0;
  int          comparisons = 0;
  cpic_mode_t  modes [4] = '{CPIC_MODE_LEGACY, CPIC_MODE_ENH, CPIC_MODE_RSVD, CPIC_MODE_FIFO};
  logic [7:0]  masks [4] = '{`CPIC_MASK_MODE0, `CPIC_MASK_MODE1, `CPIC_MASK_MODE2,
                             `CPIC_MASK_MODE2};

  always #5 pclk = ~pclk;

  cpic_top #(.NUM_ERR_SRC(4)) dut_u
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .can_mode(can_mode), .can_evt(can_evt),
    .module_err_src(err_src), .per_tx_buffer_enable_reg(ptx),
    .per_buffer_enable_reg(pbuf), .core_tx_bit(core_tx), .can_rx_msg(rx_msg),
    .capture_port_pin(port_pin), .gpio_out(gpio_o), .gpio_oe(gpio_e),
    .osc_clk(osc), .pll_clk(pll), .primary_transmit_pin_o(p_o),
    .primary_transmit_pin_oe(p_oe), .second_transmit_pin_o(s_o),
    .second_transmit_pin_oe(s_oe), .first_capture_unit_in(cap),
    .can_sys_clk(sclk), .can_irq(irq)
  );

  cpic_xcvr xcvr_u (.tx_o(p_o), .tx_oe(p_oe), .bus_level(bus_level));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic irq_chk(input logic exp);
    tick(2);
    chk(irq, exp);
  endtask

  task automatic pulse(input logic [7:0] e, input logic [3:0] er);
    @(posedge pclk);
    can_evt <= cpic_evt_t'(e);
    err_src <= er;
    @(posedge pclk);
    can_evt <= '0;
    err_src <= '0;
    @(posedge pclk);
  endtask

  // expected pin levels as {primary oe, second o, second oe}
  task automatic pins(input logic [7:0] ctl, input logic tx, input logic [2:0] exp);
    wr(`CPIC_OFF_PINCTL, {24'h0, ctl});
    @(posedge pclk);
    core_tx <= tx;
    tick(1);
    chk({p_oe, s_o, s_oe}, exp);
    chk(bus_level, tx);
  endtask

  // flag layout differs between legacy and the buffer modes; reserved code acts as fifo
  function automatic logic [7:0] exp_flag(input int m, input logic [7:0] e, input logic er);
    if (m == 0)
      return {e[7], e[6], er, e[5:3], e[2:1]};
    return {e[7], e[6], er, |e[5:3], 2'b00, |e[2:1], (m >= 2) & e[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`CPIC_OFF_PINCTL, 32'h0);
    rdc(`CPIC_OFF_FLAGS, 32'h0);
    rdc(`CPIC_OFF_ENABLES, 32'h0);
    rdc(12'h00c, 32'h0);
    chk(se, 1'b1);
    wr(`CPIC_OFF_PINCTL, 32'hff);
    rdc(`CPIC_OFF_PINCTL, 32'hf1);
    pins(8'he1, 1'b0, 3'b111);
    chk(sclk, 1'b1);
    pins(8'he0, 1'b0, 3'b101);
    chk(sclk, 1'b0);
    // differential bus: recessive driven high with 8'h60, released with 8'h00
    pins(8'h60, 1'b1, 3'b111);
    pins(8'h60, 1'b0, 3'b101);
    pins(8'h00, 1'b1, 3'b011);
    pins(8'h00, 1'b0, 3'b111);
    wr(`CPIC_OFF_PINCTL, 32'h10);
    @(posedge pclk);
    rx_msg <= 1'b1;
    tick(1);
    chk(cap, 1'b1);
    wr(`CPIC_OFF_PINCTL, 32'h00);
    tick(3);
    chk(cap, 1'b0);
    // port pin reaches the capture unit through the two-stage synchroniser
    @(posedge pclk);
    port_pin <= 1'b1;
    tick(3);
    chk(cap, 1'b1);
    @(posedge pclk);
    port_pin <= 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      @(posedge pclk);
      can_mode <= modes[m];
      wr(`CPIC_OFF_ENABLES, 32'hff);
      rdc(`CPIC_OFF_ENABLES, {24'h0, masks[m]});
      wr(`CPIC_OFF_ENABLES, 32'h0);
      for (int i = 0; i < 9; i++)
      begin
        pulse(8'h1 << i, (i == 8) ? 4'h8 : 4'h0);
        rdc(`CPIC_OFF_FLAGS, {24'h0, exp_flag(m, 8'h1 << i, i == 8)});
        wr(`CPIC_OFF_FLAGS, 32'h0);
      end
    end
    pulse(8'h08, 4'h0);
    wr(`CPIC_OFF_ENABLES, 32'h10);
    irq_chk(1'b0);
    @(posedge pclk);
    ptx <= 3'h1;
    irq_chk(1'b1);
    wr(`CPIC_OFF_ENABLES, 32'h0);
    irq_chk(1'b0);
    wr(`CPIC_OFF_FLAGS, 32'h0);
    pulse(8'h02, 4'h0);
    wr(`CPIC_OFF_ENABLES, 32'h02);
    irq_chk(1'b0);
    @(posedge pclk);
    pbuf <= 8'h01;
    irq_chk(1'b1);
    wr(`CPIC_OFF_FLAGS, 32'h0);
    irq_chk(1'b0);
    pulse(8'h01, 4'h0);
    irq_chk(1'b0);
    wr(`CPIC_OFF_ENABLES, 32'h01);
    irq_chk(1'b1);
    @(posedge pclk);
    can_mode <= CPIC_MODE_LEGACY;
    wr(`CPIC_OFF_FLAGS, 32'h0);
    pulse(8'h80, 4'h0);
    wr(`CPIC_OFF_ENABLES, 32'h7f);
    irq_chk(1'b0);
    wr(`CPIC_OFF_ENABLES, 32'h80);
    irq_chk(1'b1);
    // a reset in mid-run must clear what software left set
    @(posedge pclk);
    presetn <= 1'b0;
    core_tx <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`CPIC_OFF_FLAGS, 32'h0);
    rdc(`CPIC_OFF_ENABLES, 32'h0);
    chk(irq, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire

/* File: cpic_xcvr.sv */
// transceiver model on the primary transmit pin
`timescale 1ns/100ps
`default_nettype none
module cpic_xcvr
(
  input  wire logic tx_o,
  input  wire logic tx_oe,
  output logic      bus_level
);
  // a released pin leaves the bus to the termination, which pulls it recessive
  assign bus_level = tx_oe ? tx_o : 1'b1;
endmodule
`default_nettype wire
